// *** hw/swc_defs.vh ***
// constants for the 512-to-384 transmit stream width converter
// assumes one clock (100 MHz mac user clock) shared by user side and mac side
//
// Overview of operation
// - 512-bit user beats leave as 384-bit beats
// - 384-bit holding register keeps leftover 128-bit units
// - held count thermometer: 000, 001, 011, 111
// - output mixes user data and held units
// - empty hold: send low 384, keep upper unit
// - full-width output beat has all keep ones
// - mac not ready drops user ready
// - mac-side outputs stable while mac not ready
// - count full: stop user, flush held 384 bits
// - flush data from hold, count back empty
// - final beat keep plus count plan output
// - final overflow sets pending flag, ready low
// - final fits three units: one beat, last
`ifndef SWC_DEFS_VH
`define SWC_DEFS_VH

`define SWC_IN_W      512
`define SWC_OUT_W     384
`define SWC_UNIT_W    128
`define SWC_IN_KW     64
`define SWC_OUT_KW    48
`define SWC_UNIT_KW   16

`define SWC_CNT_EMPTY 3'b000
`define SWC_CNT_ONE   3'b001
`define SWC_CNT_TWO   3'b011
`define SWC_CNT_FULL  3'b111

`endif

// *** hw/swc_tx.v ***
// transmit width converter: 512-bit user stream in, 384-bit mac stream out
// assumes user source and mac share ref_clk; no buffer beyond the hold register
`timescale 1ns/1ps
`include "swc_defs.vh"

module swc_tx (
   input  wire                      ref_clk,
   input  wire                      rst_b,
   input  wire                      user_in_valid,
   output wire                      user_in_ready,
   input  wire [`SWC_IN_W-1:0]      user_in_word,
   input  wire [`SWC_IN_KW-1:0]     user_in_byte_en,
   input  wire                      user_in_final,
   output wire                      tx_axis_tvalid,
   input  wire                      tx_axis_tready,
   output wire [`SWC_OUT_W-1:0]     tx_axis_tdata,
   output wire [`SWC_OUT_KW-1:0]    tx_axis_tkeep,
   output wire                      tx_axis_tlast
);

   // thermometer code to unit count
   function [1:0] units_of;
      input [2:0] code;
      begin
         case (code)
            `SWC_CNT_FULL: units_of = 2'd3;
            `SWC_CNT_TWO:  units_of = 2'd2;
            `SWC_CNT_ONE:  units_of = 2'd1;
            default:       units_of = 2'd0;
         endcase
      end
   endfunction

   // unit count to thermometer code
   function [2:0] code_of;
      input [2:0] n;
      begin
         case (n)
            3'd0:    code_of = `SWC_CNT_EMPTY;
            3'd1:    code_of = `SWC_CNT_ONE;
            3'd2:    code_of = `SWC_CNT_TWO;
            default: code_of = `SWC_CNT_FULL;
         endcase
      end
   endfunction

   reg  [`SWC_OUT_W-1:0]   hold_reg;
   reg  [`SWC_OUT_KW-1:0]  hold_keep_r;
   reg  [2:0]              hold_unit_count;
   reg                     pending_final_flag;
   reg                     out_valid_r;
   reg  [`SWC_OUT_W-1:0]   out_data_r;
   reg  [`SWC_OUT_KW-1:0]  out_keep_r;
   reg                     out_last_r;

   reg  [`SWC_OUT_W-1:0]   hold_nxt;
   reg  [`SWC_OUT_KW-1:0]  hold_keep_nxt;
   reg  [2:0]              count_nxt;
   reg                     pend_nxt;
   reg                     valid_nxt;
   reg  [`SWC_OUT_W-1:0]   data_nxt;
   reg  [`SWC_OUT_KW-1:0]  keep_nxt;
   reg                     last_nxt;
   reg  [895:0]            mix;
   reg  [111:0]            mix_keep;
   reg  [2:0]              in_units;
   reg  [2:0]              total;

   wire [1:0] held = units_of(hold_unit_count);
   wire       full = (hold_unit_count == `SWC_CNT_FULL);
   wire       fits = (total <= 3'd3);

   // all state moves only when the mac can take a beat, so a waiting beat never changes
   assign user_in_ready = tx_axis_tready & ~pending_final_flag & ~full;
   wire   take = user_in_valid & user_in_ready;

   // place the user beat just above the held units
   always @* begin
      case (held)
         2'd0: begin
            mix      = {384'h0, user_in_word};
            mix_keep = {48'h0, user_in_byte_en};
         end
         2'd1: begin
            mix      = {256'h0, user_in_word, hold_reg[127:0]};
            mix_keep = {32'h0, user_in_byte_en, 16'hffff};
         end
         2'd2: begin
            mix      = {128'h0, user_in_word, hold_reg[255:0]};
            mix_keep = {16'h0, user_in_byte_en, 32'hffffffff};
         end
         default: begin
            mix      = {user_in_word, hold_reg};
            mix_keep = {user_in_byte_en, 48'hffffffffffff};
         end
      endcase
   end

   // units carried by a beat; a final beat keeps contiguous low bytes,
   // so the highest unit with its first byte kept gives the length
   // a non-final beat counts as four units whatever its keep bits say
   function [2:0] beat_units_of;
      input [`SWC_IN_KW-1:0] keep;
      input                  fin;
      begin
         if (!fin)
            beat_units_of = 3'd4;
         else if (keep[48])
            beat_units_of = 3'd4;
         else if (keep[32])
            beat_units_of = 3'd3;
         else if (keep[16])
            beat_units_of = 3'd2;
         else
            beat_units_of = 3'd1;
      end
   endfunction

   always @* begin
      in_units = beat_units_of(user_in_byte_en, user_in_final);
      total    = {1'b0, held} + in_units;
   end

   // next mac-side beat; while the mac stalls the beat on the port stands
   always @* begin
      valid_nxt = out_valid_r;
      data_nxt  = out_data_r;
      keep_nxt  = out_keep_r;
      last_nxt  = out_last_r;
      if (tx_axis_tready) begin
         valid_nxt = 1'b0;
         last_nxt  = 1'b0;
         // remainder and flush take priority over new user data
         if (pending_final_flag) begin
            valid_nxt = 1'b1;
            data_nxt  = hold_reg;
            keep_nxt  = hold_keep_r;
            last_nxt  = 1'b1;
         end else if (full) begin
            valid_nxt = 1'b1;
            data_nxt  = hold_reg;
            keep_nxt  = {`SWC_OUT_KW{1'b1}};
         end else if (take) begin
            valid_nxt = 1'b1;
            data_nxt  = mix[383:0];
            if (fits) begin
               keep_nxt = mix_keep[47:0];
               last_nxt = 1'b1;
            end else begin
               keep_nxt = {`SWC_OUT_KW{1'b1}};
            end
         end
      end
   end

   // hold side: leftover units, their keep bits and the pending final
   always @* begin
      hold_nxt      = hold_reg;
      hold_keep_nxt = hold_keep_r;
      count_nxt     = hold_unit_count;
      pend_nxt      = pending_final_flag;
      if (tx_axis_tready) begin
         if (pending_final_flag | full) begin
            // flush or remainder beat empties the hold in one cycle
            count_nxt = `SWC_CNT_EMPTY;
            pend_nxt  = 1'b0;
         end else if (take) begin
            hold_nxt = mix[767:384];
            // a final that fills at most three units leaves nothing behind
            if (fits) begin
               count_nxt = `SWC_CNT_EMPTY;
            end else begin
               count_nxt     = code_of(total - 3'd3);
               hold_keep_nxt = mix_keep[95:48];
               pend_nxt      = user_in_final;
            end
         end
      end
   end

   // held data and its keep bits
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_reg    <= {`SWC_OUT_W{1'b0}};
         hold_keep_r <= {`SWC_OUT_KW{1'b0}};
      end else begin
         hold_reg    <= hold_nxt;
         hold_keep_r <= hold_keep_nxt;
      end
   end

   // held-unit count and pending final
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_unit_count    <= `SWC_CNT_EMPTY;
         pending_final_flag <= 1'b0;
      end else begin
         hold_unit_count    <= count_nxt;
         pending_final_flag <= pend_nxt;
      end
   end

   // registered mac-side beat; zero after reset
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_valid_r <= 1'b0;
         out_data_r  <= {`SWC_OUT_W{1'b0}};
         out_keep_r  <= {`SWC_OUT_KW{1'b0}};
         out_last_r  <= 1'b0;
      end else begin
         out_valid_r <= valid_nxt;
         out_data_r  <= data_nxt;
         out_keep_r  <= keep_nxt;
         out_last_r  <= last_nxt;
      end
   end

   assign tx_axis_tvalid = out_valid_r;
   assign tx_axis_tdata  = out_data_r;
   assign tx_axis_tkeep  = out_keep_r;
   assign tx_axis_tlast  = out_last_r;

endmodule // swc_tx

// *** testbench/swc_chk.sv ***
// port assertions for swc_tx
// bound to every swc_tx instance at the foot
`timescale 1ns/1ps
module swc_chk (
   input wire        ref_clk,
   input wire        rst_b,
   input wire        user_in_valid,
   input wire        user_in_ready,
   input wire [63:0] user_in_byte_en,
   input wire        user_in_final,
   input wire        tx_axis_tvalid,
   input wire        tx_axis_tready,
   input wire [383:0] tx_axis_tdata,
   input wire [47:0] tx_axis_tkeep,
   input wire        tx_axis_tlast
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire acc = user_in_valid && user_in_ready;
   sequence s_body3; (acc && !user_in_final) [*3]; endsequence
   sequence s_big_fin; acc && user_in_final && &user_in_byte_en; endsequence
   AST_RDY_MAC: assert property (!tx_axis_tready |-> !user_in_ready) else $error("rdy");
   AST_STALL: assert property (tx_axis_tvalid && !tx_axis_tready |=>
      $stable({tx_axis_tvalid, tx_axis_tdata, tx_axis_tkeep, tx_axis_tlast})) else $error("hold");
   AST_ANSWER: assert property (acc |=> tx_axis_tvalid) else $error("answer");
   AST_KEEP_ONES: assert property (tx_axis_tvalid && !tx_axis_tlast |->
      &tx_axis_tkeep) else $error("keep");
   AST_FLUSH: assert property (s_body3 |=> !user_in_ready) else $error("flush");
   AST_DRAIN: assert property (!user_in_ready && tx_axis_tready |=>
      tx_axis_tvalid) else $error("drain");
   AST_PEND: assert property (s_big_fin |=> !user_in_ready && !tx_axis_tlast)
      else $error("pend");
   AST_REM: assert property (s_big_fin ##1 tx_axis_tready |=> tx_axis_tvalid && tx_axis_tlast)
      else $error("rem");
   AST_KEEP_ALIGN: assert property (tx_axis_tvalid && tx_axis_tlast |-> tx_axis_tkeep[0] &&
      !(tx_axis_tkeep & (tx_axis_tkeep + 48'h1))) else $error("align");
endmodule // swc_chk
bind swc_tx swc_chk chk_i (.ref_clk, .rst_b, .user_in_valid, .user_in_ready, .user_in_byte_en,
   .user_in_final, .tx_axis_tvalid, .tx_axis_tready, .tx_axis_tdata, .tx_axis_tkeep,
   .tx_axis_tlast);

// *** testbench/swc_mac_sink.sv ***
// mac sink model: ready always, or one cycle in four
// assumes slow changes only between packets
`timescale 1ns/1ps
module swc_mac_sink (
   input wire ref_clk,
   input wire rst_b,
   input wire slow,
   output reg tready = 1'b0
);
   reg [1:0] cnt_r = 2'h0;
   // slow mode stalls three cycles in four so held beats must stand
   always @(posedge ref_clk) begin
      cnt_r <= cnt_r + 2'h1;
      tready <= rst_b && (!slow || cnt_r == 2'h3);
   end
endmodule // swc_mac_sink

// *** testbench/swc_tx_tb.sv ***
// bench for swc_tx: beats checked as the mac sink takes them
// assumes swc_mac_sink drives ready, fast or stalling
`timescale 1ns/1ps
module swc_tx_tb;
   logic ref_clk = 0, rst_b = 0, slow = 0, vld = 0, fin = 0;
   logic [511:0] wd = '0;
   logic [383:0] held = '0;
   logic [63:0] be = '0;
   logic [432:0] e, exq[$];
   wire rdy, tr, tv, tl;
   wire [383:0] td;
   wire [47:0] tk;
   int n = 0, cyc = 0, n_mismatch = 0, tests_run = 0;
   swc_tx uut (.ref_clk, .rst_b, .user_in_valid(vld), .user_in_ready(rdy),
      .user_in_word(wd), .user_in_byte_en(be), .user_in_final(fin), .tx_axis_tvalid(tv),
      .tx_axis_tready(tr), .tx_axis_tdata(td), .tx_axis_tkeep(tk), .tx_axis_tlast(tl));
   swc_mac_sink mac (.ref_clk, .rst_b, .slow, .tready(tr));
   initial forever #5 ref_clk = !ref_clk;
   task chk(input [432:0] g, input [432:0] x);
      tests_run++;
      if (g !== x) begin
         n_mismatch++;
         $display("[FAIL] %0t beat mismatch", $time);
      end
   endtask
   task finish_test;
      $display("compares %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // u is the unit count of the beat; the expected beats are queued before the offer
   task send(input [7:0] s, input int u, input bit f);
      logic [895:0] c;
      logic [111:0] k;
      logic acc;
      int t;
      t = n + u;
      #1;
      for (int b = 0; b < 64; b++) wd[8*b +: 8] = s + 8'(b);
      be = {64{1'b1}} >> (64 - 16 * u);
      k = ({48'h0, be} << (16 * n)) | ((112'h1 << (16 * n)) - 1);
      c = ({384'h0, wd} << (128 * n)) | held;
      exq.push_back({c[383:0], t > 3 ? 48'hffff_ffff_ffff : k[47:0], f && t < 4});
      if (f && t > 3) exq.push_back({c[767:384], k[95:48], 1'b1});
      held = c[767:384];
      n = f ? 0 : t - 3;
      if (n == 3) exq.push_back({held, 48'hffff_ffff_ffff, 1'b0});
      if (n % 3 == 0) held = '0;
      n = n % 3;
      fin = f;
      vld = 1;
      // ready is settled by the falling edge, well clear of the taking edge
      do begin
         @(negedge ref_clk);
         acc = rdy;
         @(posedge ref_clk);
      end while (acc !== 1'b1);
   endtask
   task drain(input string nm);
      #1 vld = 0;
      for (int i = 0; i < 50 && exq.size() > 0; i++) @(posedge ref_clk);
      chk(433'(exq.size()), '0);
      $display("test %s done", nm);
   endtask
   task t_flush; // three body beats fill the hold, then a one-unit final
      send(8'h00, 4, 0);
      send(8'h40, 4, 0);
      send(8'h80, 4, 0);
      send(8'hc0, 1, 1);
      drain("flush");
   endtask
   task t_pend; // overflowing final, then a short final with shifted keep
      send(8'h11, 4, 0);
      send(8'h51, 4, 1);
      send(8'h91, 4, 0);
      send(8'hd1, 1, 1);
      send(8'h19, 4, 0);
      send(8'h59, 3, 1);
      drain("pend");
   endtask
   task t_fit; // finals landing on exactly three units
      send(8'h23, 4, 0);
      send(8'h63, 4, 0);
      send(8'ha3, 1, 1);
      send(8'he3, 4, 0);
      send(8'h37, 2, 1);
      send(8'h5b, 3, 1);
      drain("fit");
   endtask
   always @(posedge ref_clk) begin
      if (tr === 1'b1 && tv !== 1'b0) begin
         e = exq.size() ? exq.pop_front() : '1;
         for (int i = 0; i < 48; i++) if (!e[i+1]) e[8*i+49 +: 8] = td[8*i +: 8];
         chk({td, tk, tl}, e);
      end
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test;
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      #1 rst_b = 1;
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         t_flush;
         t_pend;
         t_fit;
      end
      finish_test;
   end
endmodule // swc_tx_tb
